/* File: logic/scss_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SCSS_CFG_SVH
`define SCSS_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SCSS_ADR_OSC 4'h0
`define SCSS_ADR_TMR 4'h4
`define SCSS_ADR_CFG 4'h8
`define SCSS_ADR_STAT 4'hC

// ****************************************
// Field positions
// ****************************************
`define SCSS_OSC_SCS_LSB 0
`define SCSS_OSC_FAST_RC_STABLE_FLAG 2
`define SCSS_OSC_OSC_TIMEOUT_FLAG 3
`define SCSS_OSC_IFS_LSB 4
`define SCSS_TMR_SEC_EN 0
`define SCSS_TMR_SECONDARY_RUN_MODE 1

// ****************************************
// Reset values
// ****************************************
`define SCSS_RST_SCS 2'h0
`define SCSS_RST_IFS 3'h0
`define SCSS_RST_PMODE 2'h0

// ****************************************
// Timing
// ****************************************
`define SCSS_CLK_MHZ 100
`define SCSS_CPU_START_NS 5000
`define SCSS_SETTLE_NS 4000000
`define SCSS_CPU_START_CYC ((`SCSS_CPU_START_NS*`SCSS_CLK_MHZ+999)/1000)
`define SCSS_SETTLE_CYC ((`SCSS_SETTLE_NS*`SCSS_CLK_MHZ+999)/1000)
`define SCSS_OST_EDGES 11'h400
`define SCSS_HOLD_EDGES 11'h008

`endif

/* File: logic/scss_dly_timer.sv */
// Down-counting delay timer with a done level
`timescale 1ns/1ns
module scss_dly_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_q;

  // Load on start, count down to zero; done rests high when idle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= limit;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0) && !start;
endmodule

/* File: logic/scss_edge_cnt.sv */
// Counter of falling edges on a sampled oscillator level
`timescale 1ns/1ns
module scss_edge_cnt (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic osc_in,
  input wire logic [10:0] target,
  output logic done
);
  logic prev_q;
  logic [10:0] cnt_q;

  // Clear restarts from zero so a broken switch never keeps a partial count
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cnt_q <= 11'h000;
    end else if (prev_q && !osc_in && cnt_q != target) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // Previous level for falling edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= osc_in;
    end
  end

  assign done = (cnt_q == target) && !clr;
endmodule

/* File: logic/scss_pkg.sv */
// Types shared by the clock switch sequencer
package scss_pkg;

  // Sequencer states, Gray coded along startup/OSC_STARTUP_TIMER/Q1 hold/CPU delay
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_STARTUP = 3'h1,
    ST_OST = 3'h3,
    ST_Q1HOLD = 3'h2,
    ST_CPUDLY = 3'h6
  } scss_state_t;

  // Oscillator feeding the core
  typedef enum logic [1:0] {
    SRC_PRI = 2'h0,
    SRC_SEC = 2'h1,
    SRC_RC = 2'h2
  } scss_src_t;

  // Configured kind of primary oscillator
  typedef enum logic [1:0] {
    PM_XTAL = 2'h0,
    PM_EXT = 2'h1,
    PM_RC = 2'h2
  } scss_pmode_t;

endpackage

/* File: logic/scss_top.sv */
// System clock switch sequencer with its Wishbone register file
// ****************************************
// Functional notes
// [R1] Select 00 primary, 01 secondary crystal, 10 internal RC, 11 reserved.
// [R2] Wake or power-on into RC or secondary waits the CPU start-up delay.
// [R3] Same start-up delay used entering external clock primary.
// [R4] Wake into crystal primary counts 1024 primary edges first.
// [R5] Selecting internal RC switches, clears timeout flag, stops primary.
// [R6] No switch to internal RC when primary already is internal RC.
// [R7] Stable flag stays clear about 4 ms after entering fast RC.
// [R8] Phase one held for eight falling internal RC edges.
// [R9] Selecting secondary switches, clears timeout flag, stops primary.
// [R10] Phase one held for eight falling secondary edges.
// [R11] Secondary-running flag set while secondary clocks the system.
// [R12] Software enables and stabilises secondary before selecting it.
// [R13] Secondary disabled: write 01 gives 00, write 11 gives 10.
// [R14] A switch starts only when the select field changes.
// [R15] Crystal primary withheld until 1024 start-up edges counted.
// [R16] Old oscillator keeps clocking the core during that count.
// [R17] Timeout flag set once primary drives the system.
// [R18] After start-up count, eight primary edges held in phase one.
// [R19] Clearing secondary enable in secondary run clears select bit zero.
// [R20] Secondary keeps running until the target switch completes.
// [R21] Leaving secondary to external clock primary waits start-up delay.
// [R22] Counters restart from zero at each new switch.
// ****************************************
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "scss_cfg.svh"
module scss_top #(
  parameter int SETTLE_CYC = `SCSS_SETTLE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic PRI_OSC_IN,
  input wire logic SEC_OSC_IN,
  input wire logic RC_OSC_IN,
  input wire logic WAKE_EVENT,
  output logic [1:0] SYS_CLK_SEL,
  output logic Q1_HOLD,
  output logic CPU_HOLD,
  output logic PRI_OSC_EN,
  output logic SEC_OSC_EN,
  output logic RC_OSC_EN
);
  scss_pkg::scss_state_t state_q;
  scss_pkg::scss_src_t cur_src_q;
  scss_pkg::scss_src_t tgt_src_q;
  scss_pkg::scss_src_t new_src;
  logic [1:0] clock_source_select_q;
  logic [2:0] internal_freq_select_q;
  logic [1:0] pmode_q;
  logic osc_timeout_flag_q;
  logic fast_rc_stable_flag_q;
  logic secondary_osc_enable_q;
  logic secondary_running_flag_q;
  logic need_ost_q;
  logic edge_clr_q;
  logic cpu_start_q;
  logic settle_start_q;
  logic settle_wait_q;
  logic edge_done;
  logic cpu_done;
  logic settle_done;
  logic edge_in;
  logic [10:0] edge_target;
  logic req;
  logic wr_osc;
  logic wr_tmr;
  logic wr_cfg;
  logic scs_wr;
  logic [1:0] scs_d;
  logic sw_evt;
  logic [31:0] rd_d;

  // ****************************************
  // Helper functions
  // ****************************************
  // Written value resolved against the secondary enable
  function automatic logic [1:0] resolve_scs(input logic [1:0] w,
                                             input logic en);
    // [R13] write resolution
    if (w == 2'h3) begin
      resolve_scs = 2'h2;
    end else if (w == 2'h1 && !en) begin
      resolve_scs = 2'h0;
    end else begin
      resolve_scs = w;
    end
  endfunction

  // Oscillator that a select value really names
  function automatic scss_pkg::scss_src_t src_of(input logic [1:0] s,
                                                 input logic [1:0] pm);
    // [R1] source decode
    if (s == 2'h1) begin
      src_of = scss_pkg::SRC_SEC;
    end else if (s == 2'h2 || pm == scss_pkg::PM_RC) begin
      src_of = scss_pkg::SRC_RC;
    end else begin
      src_of = scss_pkg::SRC_PRI;
    end
  endfunction

  // Sampled level of an oscillator
  function automatic logic osc_of(input scss_pkg::scss_src_t s,
                                  input logic p, input logic sc,
                                  input logic r);
    case (s)
      scss_pkg::SRC_SEC: osc_of = sc;
      scss_pkg::SRC_RC: osc_of = r;
      default: osc_of = p;
    endcase
  endfunction

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state: ack rises at the edge after the request is seen
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_osc = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `SCSS_ADR_OSC;
  assign wr_tmr = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `SCSS_ADR_TMR;
  assign wr_cfg = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `SCSS_ADR_CFG;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (WB_ADR_I)
      `SCSS_ADR_OSC: rd_d = {25'h0, internal_freq_select_q,
                             osc_timeout_flag_q, fast_rc_stable_flag_q,
                             clock_source_select_q};
      `SCSS_ADR_TMR: rd_d = {30'h0, secondary_running_flag_q,
                             secondary_osc_enable_q};
      `SCSS_ADR_CFG: rd_d = {30'h0, pmode_q};
      `SCSS_ADR_STAT: rd_d = {25'h0, state_q, cur_src_q, tgt_src_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Ack and read data registered
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd_d : 32'h0000_0000;
    end
  end

  // ****************************************
  // Select field and switch request
  // ****************************************
  // Next select value from either register write
  always_comb begin
    scs_d = clock_source_select_q;
    scs_wr = 1'b0;
    if (wr_osc) begin
      scs_d = resolve_scs(WB_DAT_I[1:0], secondary_osc_enable_q);
      scs_wr = 1'b1;
    end else if (wr_tmr && !WB_DAT_I[`SCSS_TMR_SEC_EN]
                 && clock_source_select_q == 2'h1) begin
      // [R19] drop low select bit
      scs_d = {clock_source_select_q[1], 1'b0};
      scs_wr = 1'b1;
    end
  end

  assign new_src = src_of(scs_d, pmode_q);
  // [R14] switch only on a real change
  // [R6] compare the real sources, so an RC primary never switches to RC
  assign sw_evt = scs_wr && (scs_d != clock_source_select_q)
                  && (new_src != src_of(clock_source_select_q, pmode_q));

  // Software written fields
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      clock_source_select_q <= `SCSS_RST_SCS;
      internal_freq_select_q <= `SCSS_RST_IFS;
      secondary_osc_enable_q <= 1'b0;
      pmode_q <= `SCSS_RST_PMODE;
    end else begin
      clock_source_select_q <= scs_d;
      if (wr_osc) begin
        internal_freq_select_q <= WB_DAT_I[6:4];
      end
      if (wr_tmr) begin
        secondary_osc_enable_q <= WB_DAT_I[`SCSS_TMR_SEC_EN];
      end
      if (wr_cfg) begin
        pmode_q <= WB_DAT_I[1:0];
      end
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  // Edge source and count: primary during OSC_STARTUP_TIMER, target during Q1 hold
  assign edge_in = (state_q == scss_pkg::ST_OST ||
                    state_q == scss_pkg::ST_STARTUP) ? PRI_OSC_IN :
                   osc_of(tgt_src_q, PRI_OSC_IN, SEC_OSC_IN, RC_OSC_IN);
  assign edge_target = (state_q == scss_pkg::ST_Q1HOLD) ?
                       `SCSS_HOLD_EDGES : `SCSS_OST_EDGES;

  scss_edge_cnt u_edge (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .clr(edge_clr_q),
    .osc_in(edge_in),
    .target(edge_target),
    .done(edge_done)
  );

  scss_dly_timer #(.W(10)) u_cpu_dly (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .start(cpu_start_q),
    .limit(10'(`SCSS_CPU_START_CYC)),
    .done(cpu_done)
  );

  scss_dly_timer #(.W(20)) u_settle (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .start(settle_start_q),
    .limit(20'(SETTLE_CYC)),
    .done(settle_done)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Main switch sequence; a new request restarts from any state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= scss_pkg::ST_STARTUP;
      cur_src_q <= scss_pkg::SRC_PRI;
      tgt_src_q <= scss_pkg::SRC_PRI;
      need_ost_q <= 1'b0;
      edge_clr_q <= 1'b1;
      cpu_start_q <= 1'b1;
      osc_timeout_flag_q <= 1'b0;
    end else begin
      edge_clr_q <= 1'b0;
      cpu_start_q <= 1'b0;
      if (sw_evt) begin
        // [R22] restart counters
        edge_clr_q <= 1'b1;
        tgt_src_q <= new_src;
        if (new_src != scss_pkg::SRC_PRI) begin
          // [R5] [R9] leaving primary clears timeout flag
          osc_timeout_flag_q <= 1'b0;
          state_q <= scss_pkg::ST_Q1HOLD;
        end else if (pmode_q == scss_pkg::PM_XTAL) begin
          // [R15] crystal start-up count first
          state_q <= scss_pkg::ST_OST;
        end else begin
          state_q <= scss_pkg::ST_Q1HOLD;
        end
      end else if (WAKE_EVENT && state_q == scss_pkg::ST_RUN) begin
        // [R2] [R4] wake start-up delay, OSC_STARTUP_TIMER in parallel for crystal
        state_q <= scss_pkg::ST_STARTUP;
        edge_clr_q <= 1'b1;
        cpu_start_q <= 1'b1;
      end else begin
        case (state_q)
          scss_pkg::ST_STARTUP: begin
            need_ost_q <= cur_src_q == scss_pkg::SRC_PRI &&
                          pmode_q == scss_pkg::PM_XTAL;
            if (!cpu_start_q && !edge_clr_q && cpu_done &&
                (edge_done || !need_ost_q)) begin
              state_q <= scss_pkg::ST_RUN;
              if (cur_src_q == scss_pkg::SRC_PRI) begin
                osc_timeout_flag_q <= 1'b1;
              end
            end
          end
          scss_pkg::ST_OST: begin
            // [R16] core stays on the current oscillator
            if (!edge_clr_q && edge_done) begin
              edge_clr_q <= 1'b1;
              state_q <= scss_pkg::ST_Q1HOLD;
            end
          end
          scss_pkg::ST_Q1HOLD: begin
            // [R8] [R10] [R18] release after eight target edges
            if (!edge_clr_q && edge_done) begin
              cur_src_q <= tgt_src_q;
              if (tgt_src_q == scss_pkg::SRC_PRI) begin
                // [R17] primary now drives the system
                osc_timeout_flag_q <= 1'b1;
              end
              if (tgt_src_q == scss_pkg::SRC_PRI &&
                  pmode_q == scss_pkg::PM_EXT) begin
                // [R3] [R21] external clock primary start-up delay
                state_q <= scss_pkg::ST_CPUDLY;
                cpu_start_q <= 1'b1;
              end else begin
                state_q <= scss_pkg::ST_RUN;
              end
            end
          end
          scss_pkg::ST_CPUDLY: begin
            if (!cpu_start_q && cpu_done) begin
              state_q <= scss_pkg::ST_RUN;
            end
          end
          default: state_q <= scss_pkg::ST_RUN;
        endcase
      end
    end
  end

  // Fast RC settle tracking for the stable flag
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fast_rc_stable_flag_q <= 1'b0;
      settle_wait_q <= 1'b0;
      settle_start_q <= 1'b0;
    end else begin
      settle_start_q <= 1'b0;
      // Frequency written with the select counts, not the stale one
      if (sw_evt && new_src == scss_pkg::SRC_RC &&
          cur_src_q != scss_pkg::SRC_RC &&
          (wr_osc ? WB_DAT_I[6:4] : internal_freq_select_q) != 3'h0) begin
        // [R7] flag held clear while the fast oscillator settles
        fast_rc_stable_flag_q <= 1'b0;
        settle_wait_q <= 1'b1;
        settle_start_q <= 1'b1;
      end else if (settle_wait_q && !settle_start_q && settle_done) begin
        fast_rc_stable_flag_q <= 1'b1;
        settle_wait_q <= 1'b0;
      end
    end
  end

  // Registered outputs and running flag, one cycle behind the state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SYS_CLK_SEL <= 2'h0;
      Q1_HOLD <= 1'b0;
      CPU_HOLD <= 1'b1;
      PRI_OSC_EN <= 1'b1;
      SEC_OSC_EN <= 1'b0;
      RC_OSC_EN <= 1'b0;
      secondary_running_flag_q <= 1'b0;
    end else begin
      SYS_CLK_SEL <= cur_src_q;
      Q1_HOLD <= state_q == scss_pkg::ST_Q1HOLD;
      CPU_HOLD <= state_q == scss_pkg::ST_STARTUP ||
                  state_q == scss_pkg::ST_CPUDLY;
      // Primary powered only when in use or being started
      PRI_OSC_EN <= cur_src_q == scss_pkg::SRC_PRI ||
                    tgt_src_q == scss_pkg::SRC_PRI;
      // [R20] secondary kept alive until the switch away completes
      SEC_OSC_EN <= secondary_osc_enable_q || cur_src_q == scss_pkg::SRC_SEC;
      RC_OSC_EN <= cur_src_q == scss_pkg::SRC_RC ||
                   tgt_src_q == scss_pkg::SRC_RC;
      // [R11] secondary running indication
      secondary_running_flag_q <= cur_src_q == scss_pkg::SRC_SEC;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_ost_done;
    state_q == scss_pkg::ST_OST && !edge_clr_q && edge_done;
  endsequence

  sequence s_hold_done;
    state_q == scss_pkg::ST_Q1HOLD && !edge_clr_q && edge_done;
  endsequence

  AST_WR_RESERVED: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R13]
    wr_osc && WB_DAT_I[1:0] == 2'h3 |=> clock_source_select_q == 2'h2)
    else $error("select write 11 did not give 10");

  AST_WR_SEC_OFF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R13]
    wr_osc && WB_DAT_I[1:0] == 2'h1 && !secondary_osc_enable_q
    |=> clock_source_select_q == 2'h0)
    else $error("select write 01 with secondary off not 00");

  AST_EN_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R19]
    wr_tmr && !WB_DAT_I[0] && clock_source_select_q == 2'h1
    |=> !clock_source_select_q[0])
    else $error("enable clear kept select bit zero");

  AST_NO_CHANGE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R14]
    !scs_wr && state_q == scss_pkg::ST_RUN && !WAKE_EVENT
    |=> state_q == scss_pkg::ST_RUN)
    else $error("switch started without select change");

  AST_TIMEOUT_CLR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R5]
    sw_evt && new_src != scss_pkg::SRC_PRI |=> !osc_timeout_flag_q)
    else $error("timeout flag not cleared on switch away");

  AST_OST_TO_HOLD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R18]
    s_ost_done and !sw_evt |=> state_q == scss_pkg::ST_Q1HOLD ##1
    state_q != scss_pkg::ST_Q1HOLD || !edge_done)
    else $error("OSC_STARTUP_TIMER end did not start a fresh eight edge hold");

  AST_HOLD_PRI: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R17]
    s_hold_done and !sw_evt and tgt_src_q == scss_pkg::SRC_PRI
    |=> osc_timeout_flag_q ##1 SYS_CLK_SEL == 2'h0)
    else $error("timeout flag or clock select wrong after primary hold");

  AST_OST_KEEP_CLK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R16]
    state_q == scss_pkg::ST_OST ##1 state_q == scss_pkg::ST_OST
    |-> $stable(cur_src_q))
    else $error("core clock changed during start-up count");

  AST_SECONDARY_RUN_MODE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R11]
    cur_src_q == scss_pkg::SRC_SEC ##1 cur_src_q == scss_pkg::SRC_SEC
    |-> secondary_running_flag_q && SEC_OSC_EN)
    else $error("secondary running flag or enable low");

  AST_SETTLE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R7]
    settle_wait_q && !settle_done |-> !fast_rc_stable_flag_q)
    else $error("stable flag set before settle time");
endmodule

/* File: testbench/scss_osc_model.sv */
// Oscillator sources that feed the sequencer's sampled clock inputs
`timescale 1ns/1ns
module scss_osc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pri_en,
  input wire logic sec_en,
  input wire logic rc_en,
  output logic pri_osc,
  output logic sec_osc,
  output logic rc_osc
);
  logic [1:0] sec_cnt_q;

  // A stopped source stands still, so stray edges never reach the counters
  always_ff @(posedge clk) begin
    if (rst) begin
      pri_osc <= 1'b0;
      rc_osc <= 1'b0;
    end else begin
      pri_osc <= pri_en ? ~pri_osc : pri_osc;
      rc_osc <= rc_en ? ~rc_osc : rc_osc;
    end
  end

  // secondary also stands still while disabled
  // Slow crystal: one toggle every third cycle while enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_cnt_q <= 2'h0;
      sec_osc <= 1'b0;
    end else if (sec_en) begin
      sec_cnt_q <= (sec_cnt_q == 2'h2) ? 2'h0 : sec_cnt_q + 2'h1;
      sec_osc <= (sec_cnt_q == 2'h2) ? ~sec_osc : sec_osc;
    end
  end
endmodule

/* File: testbench/system_clock_switch_sequencer_tb_top.sv */
// Self-checking bench for the clock switch sequencer
`timescale 1ns/1ns
`include "scss_cfg.svh"
module system_clock_switch_sequencer_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic wake = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, q1_hold, cpu_hold, pri_en, sec_en, rc_en, pri, sec, rc;
  logic [1:0] clk_sel;
  logic [1:0] s;
  logic [2:0] f;
  logic [31:0] q;
  logic [31:0] r = 32'h2974;
  int errors = 0;
  int n_compared = 0;
  int t, n;

  scss_top #(.SETTLE_CYC(50)) uut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PRI_OSC_IN(pri), .SEC_OSC_IN(sec),
    .RC_OSC_IN(rc), .WAKE_EVENT(wake), .SYS_CLK_SEL(clk_sel),
    .Q1_HOLD(q1_hold), .CPU_HOLD(cpu_hold), .PRI_OSC_EN(pri_en),
    .SEC_OSC_EN(sec_en), .RC_OSC_EN(rc_en)
  );

  scss_osc_model osc (
    .clk(sys_clk), .rst(sys_rst), .pri_en(pri_en), .sec_en(sec_en),
    .rc_en(rc_en), .pri_osc(pri), .sec_osc(sec), .rc_osc(rc)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Least cycles for e falling edges of a source toggling every h cycles
  function automatic int min_cyc(input int e, input int h);
    return (e - 1) * 2 * h;
  endfunction

  // Start-up delay is roughly 5 to 10 us, with a little slack
  function automatic logic dly_ok(input int c);
    return c >= `SCSS_CPU_START_CYC - 5 &&
      c <= 2 * `SCSS_CPU_START_CYC + 5;
  endfunction

  function automatic logic lvl(input int w);
    return w == 0 ? q1_hold : (w == 1 ? cpu_hold : (q1_hold | cpu_hold));
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic cycle held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] m, output logic [31:0] o);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= m;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    o = dat_o;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] o;
    wb(1'b1, a, d, 4'hF, o);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] o);
    wb(1'b0, a, 32'h0, 4'hF, o);
  endtask

  // Wait for a hold to rise, time its length, let registered outputs land
  task automatic hold_len(input int w, output int tw, output int nh);
    tw = 0;
    nh = 0;
    while (lvl(w) !== 1'b1 && tw < 5000) begin
      @(posedge sys_clk);
      tw++;
    end
    while (lvl(w) === 1'b1 && nh < 5000) begin
      @(posedge sys_clk);
      nh++;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic test_done;
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hang costs a mismatch and ends the run in the usual place
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    test_done;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk(cpu_hold, 1'b1);
    hold_len(2, t, n);
    chk(n >= min_cyc(1024, 1), 1'b1);
    rd(`SCSS_ADR_OSC, q);
    chk(q[1:0], 2'h0);
    chk(q[3], 1'b1);
    rd(4'h2, q);
    chk(q, 32'h0);
    // Lane zero off: the write is dropped
    wb(1'b1, `SCSS_ADR_OSC, 32'h2, 4'hE, q);
    rd(`SCSS_ADR_OSC, q);
    chk(q[1:0], 2'h0);
    wr(`SCSS_ADR_OSC, 32'h1);
    rd(`SCSS_ADR_OSC, q);
    chk(q[1:0], 2'h0);
    chk(clk_sel, 2'h0);
    // Into internal RC at a random fast frequency
    r = lfsr(r);
    f = 3'(r % 7) + 3'h1;
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h3});
    rd(`SCSS_ADR_OSC, q);
    chk(q[1:0], 2'h2);
    chk(q[3], 1'b0);
    chk(q[2], 1'b0);
    hold_len(0, t, n);
    chk(n >= min_cyc(8, 1), 1'b1);
    chk(clk_sel, 2'h2);
    chk(pri_en, 1'b0);
    repeat (60) @(posedge sys_clk);
    rd(`SCSS_ADR_OSC, q);
    chk(q[2], 1'b1);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    hold_len(1, t, n);
    chk(dly_ok(n), 1'b1);
    // Back to crystal primary, interrupted once mid-count
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h0});
    repeat (300) @(posedge sys_clk);
    chk(clk_sel, 2'h2);
    chk(q1_hold, 1'b0);
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h2});
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h0});
    // Let the short hold of the cut RC switch leave the output
    @(posedge sys_clk);
    hold_len(0, t, n);
    chk(t >= min_cyc(1024, 1), 1'b1);
    chk(n >= min_cyc(8, 1), 1'b1);
    rd(`SCSS_ADR_OSC, q);
    chk(q[3], 1'b1);
    chk(clk_sel, 2'h0);
    // Secondary crystal, enabled and settled first
    wr(`SCSS_ADR_TMR, 32'h1);
    repeat (30) @(posedge sys_clk);
    r = lfsr(r);
    wb(1'b1, `SCSS_ADR_OSC, 32'h1, {r[2:0], 1'b1}, q);
    hold_len(0, t, n);
    chk(n >= min_cyc(8, 3), 1'b1);
    chk(clk_sel, 2'h1);
    chk(pri_en, 1'b0);
    rd(`SCSS_ADR_TMR, q);
    chk(q[1], 1'b1);
    rd(`SCSS_ADR_OSC, q);
    chk(q[3], 1'b0);
    wr(`SCSS_ADR_TMR, 32'h0);
    rd(`SCSS_ADR_OSC, q);
    chk(q[1:0], 2'h0);
    repeat (300) @(posedge sys_clk);
    chk(clk_sel, 2'h1);
    chk(sec_en, 1'b1);
    hold_len(0, t, n);
    chk(sec_en, 1'b0);
    rd(`SCSS_ADR_TMR, q);
    chk(q[1], 1'b0);
    // External clock primary skips the crystal count but waits start-up
    wr(`SCSS_ADR_CFG, 32'h1);
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h2});
    hold_len(0, t, n);
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h0});
    hold_len(1, t, n);
    chk(t < min_cyc(1024, 1), 1'b1);
    chk(dly_ok(n), 1'b1);
    // Primary already internal RC: selecting RC changes nothing
    wr(`SCSS_ADR_CFG, 32'h2);
    repeat (1000) @(posedge sys_clk);
    s = clk_sel;
    wr(`SCSS_ADR_OSC, {25'h0, f, 4'h2});
    repeat (60) @(posedge sys_clk);
    chk(clk_sel, s);
    chk(q1_hold, 1'b0);
    test_done;
  end
endmodule
